//--- design/asp_pkg.sv
// Constants and types shared by the serial host port of the converter
package asp_pkg;

  // ----------------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------------
  localparam int unsigned WORD_BITS   = 24;  // Every serial word
  localparam int unsigned CTRL_BU_POS = 12;  // Control bit: 1 = unipolar

  // ----------------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------------
  localparam logic [23:0] CTRL_RST = 24'h000000;
  localparam logic [23:0] OFFS_RST = 24'h000000;
  localparam logic [23:0] GAIN_RST = 24'h000000;
  localparam logic [23:0] DATA_RST = 24'h000000;

  // Synchroniser reset: both strobes idle high, everything else low
  localparam logic [7:0]  SYNC_RST = 8'h03;

  // ----------------------------------------------------------------------
  // Timing of the self-made serial clock
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 4;   // core_clk at 250 MHz
  localparam int unsigned SCLK_HALF_NS  = 16;  // Least half period
  localparam int unsigned SCLK_HALF_CYC =
    (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    CK_IDLE = 2'b00,
    CK_RUN  = 2'b01,
    CK_DONE = 2'b10
  } asp_ck_state_type;

  typedef enum logic [1:0] {
    SRC_CTRL = 2'b00,
    SRC_OFFS = 2'b01,
    SRC_GAIN = 2'b10,
    SRC_DATA = 2'b11
  } asp_src_type;

endpackage : asp_pkg

//--- design/asp_serial_port.sv
// Serial host port: frame strobes, shared data line, serial clock, ready
`timescale 1ns/1ps

// Function
// - Self-clocking: device starts the serial clock only after write strobe low.
// - Write data is sampled on rising serial clock edges while strobe is low.
// - Self-clocking: clock and data drivers turn on only after read strobe low.
// - External clocking: data driver turns on only after read strobe low.
// - A data register read starts driving only while ready output is low.
// - Ready output falls whenever a new conversion result is available.
// - Ready output returns high once a full data word has been read.
// - Ready output also falls when calibration has finished.
// - Writes load the control register or a calibration register.
// - Reads return control, calibration or conversion data register.
// - Results are natural binary when unipolar, offset binary when bipolar.
// - Mode input high selects self-clocking, low selects external clocking.
// - Only a full 24-bit write loads; clocks after the 24th are ignored.
module asp_serial_port #(
  parameter int unsigned WORD_W = asp_pkg::WORD_BITS
) (
  // Core clock and reset
  input  wire logic              core_clk,
  input  wire logic              nrst,
  // Serial clock as seen on the wire
  input  wire logic              link_clk,
  // Frame strobes and selects from the host
  input  wire logic              write_frame_strobe_n,
  input  wire logic              read_frame_strobe_n,
  input  wire logic              register_select,
  input  wire logic              cal_access,
  input  wire logic              cal_sel,
  input  wire logic              mode_sel,
  // Shared data line
  input  wire logic              serial_io_in,
  output logic                   serial_io_out,
  output logic                   serial_io_oe_n,
  // Serial clock driver for self-clocking mode
  output logic                   sclk_out,
  output logic                   sclk_oe_n,
  // Ready output
  output logic                   result_ready_n,
  // Converter side
  input  wire logic              result_valid,
  input  wire logic [WORD_W-1:0] raw_result,
  input  wire logic              cal_done,
  input  wire logic [WORD_W-1:0] cal_offset_in,
  input  wire logic [WORD_W-1:0] cal_gain_in,
  output logic      [WORD_W-1:0] ctrl_word,
  output logic      [WORD_W-1:0] offset_cal,
  output logic      [WORD_W-1:0] gain_cal
);

  localparam int unsigned CNT_W = $clog2(WORD_W + 1);
  localparam int unsigned HC_W  = $clog2(asp_pkg::SCLK_HALF_CYC + 1);
  localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(WORD_W - 1);
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(WORD_W);
  localparam logic [HC_W-1:0]  HALF_END = HC_W'(asp_pkg::SCLK_HALF_CYC - 1);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [7:0]        sync1_r;
  logic [7:0]        sync2_r;
  logic              link_rst_r;
  logic              wr_tgl_q_r;
  logic              rd_tgl_q_r;
  logic              wr_strobe_q_r;
  logic              rd_strobe_q_r;
  logic              rd_active_r;
  logic              rd_active_nxt;
  asp_pkg::asp_src_type rd_src_r;
  asp_pkg::asp_src_type wr_dest_r;
  logic [WORD_W-1:0] rd_word_r;
  logic [WORD_W-1:0] ctrl_r;
  logic [WORD_W-1:0] offs_r;
  logic [WORD_W-1:0] gain_r;
  logic [WORD_W-1:0] data_r;
  logic              ready_n_r;
  logic              ready_n_nxt;
  asp_pkg::asp_ck_state_type ck_state_r;
  logic [HC_W-1:0]   half_cnt_r;
  logic [CNT_W-1:0]  edge_cnt_r;
  logic              sclk_r;
  // Link domain
  logic [CNT_W-1:0]  wr_cnt_r;
  logic [WORD_W-1:0] wr_shift_r;
  logic [WORD_W-1:0] wr_word_r;
  logic              wr_tgl_r;
  logic [CNT_W-1:0]  rd_cnt_r;
  logic              rd_tgl_r;

  // ----------------------------------------------------------------------
  // Crossing into the core domain
  // ----------------------------------------------------------------------
  // Two flip-flops on every strobe and select level and on both link toggles
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      sync1_r <= asp_pkg::SYNC_RST;
      sync2_r <= asp_pkg::SYNC_RST;
    end else begin
      sync1_r <= {rd_tgl_r, wr_tgl_r, cal_sel, cal_access, mode_sel,
                  register_select, read_frame_strobe_n,
                  write_frame_strobe_n};
      sync2_r <= sync1_r;
    end
  end

  // Named views of the synchronised levels
  wire wr_strobe_s = sync2_r[0];
  wire rd_strobe_s = sync2_r[1];
  wire rsel_s      = sync2_r[2];
  wire self_mode_s = sync2_r[3];
  wire cal_acc_s   = sync2_r[4];
  wire cal_sel_s   = sync2_r[5];
  wire wr_tgl_s    = sync2_r[6];
  wire rd_tgl_s    = sync2_r[7];

  // Events and frame edges seen by the core
  wire wr_evt   = wr_tgl_s ^ wr_tgl_q_r;
  wire rd_evt   = rd_tgl_s ^ rd_tgl_q_r;
  wire rd_start = rd_strobe_q_r & ~rd_strobe_s;
  wire wr_start = wr_strobe_q_r & ~wr_strobe_s;

  // Register addressed by the selects of the current frame
  wire asp_pkg::asp_src_type sel_src =
    !rsel_s   ? asp_pkg::SRC_CTRL :
    !cal_acc_s ? asp_pkg::SRC_DATA :
    cal_sel_s  ? asp_pkg::SRC_GAIN : asp_pkg::SRC_OFFS;
  wire [WORD_W-1:0] sel_word =
    (sel_src == asp_pkg::SRC_CTRL) ? ctrl_r :
    (sel_src == asp_pkg::SRC_OFFS) ? offs_r :
    (sel_src == asp_pkg::SRC_GAIN) ? gain_r : data_r;

  // A data read starts only if a result is pending at frame start; others start at once
  wire rd_gate = (sel_src != asp_pkg::SRC_DATA) | ~ready_n_r;
  assign rd_active_nxt = rd_strobe_s ? 1'b0 :
                         (rd_active_r | (rd_start & rd_gate));

  // Ready falls on a result or end of calibration; a new event wins
  wire rd_data_done = rd_evt & rd_active_r &
                      (rd_src_r == asp_pkg::SRC_DATA);
  assign ready_n_nxt = (result_valid | cal_done) ? 1'b0 :
                       rd_data_done ? 1'b1 : ready_n_r;

  // Result coding: offset binary flips the sign bit
  wire unipolar = ctrl_r[asp_pkg::CTRL_BU_POS];
  wire [WORD_W-1:0] coded_result = unipolar ? raw_result :
    {~raw_result[WORD_W-1], raw_result[WORD_W-2:0]};

  // ----------------------------------------------------------------------
  // Frame tracking and read set-up
  // ----------------------------------------------------------------------
  // Edge history, link reset and read word capture at frame start
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      link_rst_r    <= 1'b1;
      wr_tgl_q_r    <= 1'b0;
      rd_tgl_q_r    <= 1'b0;
      wr_strobe_q_r <= 1'b1;
      rd_strobe_q_r <= 1'b1;
      rd_active_r   <= 1'b0;
      rd_src_r      <= asp_pkg::SRC_CTRL;
      wr_dest_r     <= asp_pkg::SRC_CTRL;
      rd_word_r     <= asp_pkg::CTRL_RST;
    end else begin
      link_rst_r    <= 1'b0;
      wr_tgl_q_r    <= wr_tgl_s;
      rd_tgl_q_r    <= rd_tgl_s;
      wr_strobe_q_r <= wr_strobe_s;
      rd_strobe_q_r <= rd_strobe_s;
      rd_active_r   <= rd_active_nxt;
      if (wr_start)
        wr_dest_r <= sel_src;
      if (rd_start) begin
        rd_src_r  <= sel_src;
        rd_word_r <= sel_word;  // Held still for the whole frame
      end
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // A completed write beats a calibration update in the same cycle
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ctrl_r    <= asp_pkg::CTRL_RST;
      offs_r    <= asp_pkg::OFFS_RST;
      gain_r    <= asp_pkg::GAIN_RST;
      data_r    <= asp_pkg::DATA_RST;
      ready_n_r <= 1'b1;
    end else begin
      ready_n_r <= ready_n_nxt;
      if (result_valid)
        data_r <= coded_result;
      if (wr_evt && wr_dest_r == asp_pkg::SRC_CTRL)
        ctrl_r <= wr_word_r;
      if (wr_evt && wr_dest_r == asp_pkg::SRC_OFFS)
        offs_r <= wr_word_r;
      else if (cal_done)
        offs_r <= cal_offset_in;
      if (wr_evt && wr_dest_r == asp_pkg::SRC_GAIN)
        gain_r <= wr_word_r;
      else if (cal_done)
        gain_r <= cal_gain_in;
    end
  end

  // ----------------------------------------------------------------------
  // Self-made serial clock
  // ----------------------------------------------------------------------
  // Runs only inside a frame: write strobe low or a read under way
  wire ck_req = self_mode_s & (~wr_strobe_s | rd_active_r);
  wire half_end = (half_cnt_r == HALF_END);

  // Idle high, 24 rising edges per frame, then parked high
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ck_state_r <= asp_pkg::CK_IDLE;
      half_cnt_r <= '0;
      edge_cnt_r <= '0;
      sclk_r     <= 1'b1;
    end else begin
      case (ck_state_r)
        asp_pkg::CK_IDLE: begin
          half_cnt_r <= '0;
          edge_cnt_r <= '0;
          sclk_r     <= 1'b1;
          if (ck_req)
            ck_state_r <= asp_pkg::CK_RUN;
        end
        asp_pkg::CK_RUN: begin
          half_cnt_r <= half_end ? '0 : half_cnt_r + 1'b1;
          if (half_end)
            sclk_r <= ~sclk_r;
          if (half_end && !sclk_r)
            edge_cnt_r <= edge_cnt_r + 1'b1;
          if (!ck_req)
            ck_state_r <= asp_pkg::CK_IDLE;
          else if (half_end && !sclk_r && edge_cnt_r == LAST_BIT)
            ck_state_r <= asp_pkg::CK_DONE;
        end
        asp_pkg::CK_DONE: begin
          sclk_r <= 1'b1;
          if (!ck_req)
            ck_state_r <= asp_pkg::CK_IDLE;
        end
        default: ck_state_r <= asp_pkg::CK_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Link domain: write shifter
  // ----------------------------------------------------------------------
  // Strobe high clears the bit count, so a short write loads nothing
  wire wr_clr = write_frame_strobe_n | link_rst_r;
  wire rd_clr = read_frame_strobe_n | link_rst_r;

  // Shift in on rising edges, MSB first, ignore edges past the 24th
  always_ff @(posedge link_clk or posedge wr_clr) begin
    if (wr_clr) begin
      wr_cnt_r   <= '0;
      wr_shift_r <= '0;
    end else if (wr_cnt_r != FULL_CNT) begin
      wr_cnt_r   <= wr_cnt_r + 1'b1;
      wr_shift_r <= {wr_shift_r[WORD_W-2:0], serial_io_in};
    end
  end

  // Full word captured and announced to the core by a toggle
  always_ff @(posedge link_clk or posedge link_rst_r) begin
    if (link_rst_r) begin
      wr_word_r <= '0;
      wr_tgl_r  <= 1'b0;
    end else if (!write_frame_strobe_n && wr_cnt_r == LAST_BIT) begin
      wr_word_r <= {wr_shift_r[WORD_W-2:0], serial_io_in};
      wr_tgl_r  <= ~wr_tgl_r;
    end
  end

  // ----------------------------------------------------------------------
  // Link domain: read bit counter
  // ----------------------------------------------------------------------
  // Host samples each bit on a rising edge; the next bit follows
  always_ff @(posedge link_clk or posedge rd_clr) begin
    if (rd_clr)
      rd_cnt_r <= '0;
    else if (rd_cnt_r != FULL_CNT)
      rd_cnt_r <= rd_cnt_r + 1'b1;
  end

  // Word completion announced to the core by a toggle
  always_ff @(posedge link_clk or posedge link_rst_r) begin
    if (link_rst_r)
      rd_tgl_r <= 1'b0;
    else if (!read_frame_strobe_n && rd_cnt_r == LAST_BIT)
      rd_tgl_r <= ~rd_tgl_r;
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Bit select from the held word, MSB first; zero after the last bit
  wire [CNT_W-1:0] rd_idx = LAST_BIT - rd_cnt_r;
  assign serial_io_out  = (rd_cnt_r != FULL_CNT) & rd_word_r[rd_idx];
  assign serial_io_oe_n = ~rd_active_r;
  assign sclk_out       = sclk_r;
  assign sclk_oe_n      = ~(self_mode_s &
                            (ck_state_r != asp_pkg::CK_IDLE));
  assign result_ready_n = ready_n_r;
  assign ctrl_word      = ctrl_r;
  assign offset_cal     = offs_r;
  assign gain_cal       = gain_r;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_ready_on_result: assert property (result_valid |=> !result_ready_n)
    else $error("ready did not fall after a new result");
  a_ready_on_cal: assert property (cal_done |=> !result_ready_n)
    else $error("ready did not fall after calibration");
  a_ready_release: assert property (
    rd_data_done && !result_valid && !cal_done |=> result_ready_n)
    else $error("ready not released after a full data read");
  a_data_read_gate: assert property (
    $rose(rd_active_r) && rd_src_r == asp_pkg::SRC_DATA
      |-> $past(ready_n_r) == 1'b0)
    else $error("data read began with no result pending");
  a_data_oe_frame: assert property (
    !serial_io_oe_n |-> $past(!rd_strobe_s))
    else $error("data driver on outside a read frame");
  a_sclk_frame: assert property (
    $fell(sclk_oe_n) |-> self_mode_s && $past(ck_req))
    else $error("serial clock driven without a frame");
  a_ext_no_sclk: assert property (
    !self_mode_s && !$past(self_mode_s) |-> sclk_oe_n && ck_state_r == asp_pkg::CK_IDLE)
    else $error("serial clock driven in external mode");
  a_ctrl_load: assert property (
    wr_evt && wr_dest_r == asp_pkg::SRC_CTRL
      |=> ctrl_r == $past(wr_word_r))
    else $error("control register not loaded by a full write");
  a_bipolar_code: assert property (
    result_valid && !unipolar |=>
      data_r == {~$past(raw_result[WORD_W-1]), $past(raw_result[WORD_W-2:0])})
    else $error("bipolar result not offset binary");
  a_edge_limit: assert property (
    ck_state_r == asp_pkg::CK_DONE |-> edge_cnt_r == FULL_CNT && sclk_r)
    else $error("self clock gave other than a full word");
  a_write_limit: assert property (
    @(posedge link_clk) disable iff (link_rst_r) wr_cnt_r <= FULL_CNT)
    else $error("write bit count ran past the word");

  c_ctrl_write: cover property (wr_evt && wr_dest_r == asp_pkg::SRC_CTRL);
  c_data_read: cover property (rd_data_done);
  c_self_frame: cover property (ck_state_r == asp_pkg::CK_DONE);
  c_held_read: cover property (rd_start && !rd_gate);

endmodule : asp_serial_port

//--- verif/asp_host_model.sv
// Host model: frame strobes, external serial clock and write data
`timescale 1ns/1ps

module asp_host_model (
  // Mode and wire levels
  input  wire logic mode_sel,
  input  wire logic link_wire,
  input  wire logic io_wire,
  // Host drivers
  output logic      host_clk,
  output logic      host_drv,
  output logic      host_bit,
  output logic      write_frame_strobe_n,
  output logic      read_frame_strobe_n
);
  // ----------------------------------------------------------------------
  // Idle levels
  // ----------------------------------------------------------------------
  initial begin
    host_clk = 1'b1;
    host_drv = 1'b0;
    host_bit = 1'b0;
    write_frame_strobe_n = 1'b1;
    read_frame_strobe_n  = 1'b1;
  end

  // One bit slot: clock low phase, act, then rising edge
  task automatic slot(input logic wr, input logic b, output logic s);
    if (!mode_sel) begin
      host_clk = 1'b0;
      #12;
    end else begin
      @(negedge link_wire);
      #5;
    end
    if (wr) host_bit = b;  // bit ready before its rising edge
    s = io_wire;
    #4;
    if (!mode_sel) begin
      host_clk = 1'b1;
      #16;
    end
  endtask : slot

  // Write n bits, MSB first; bits past 24 are filler
  task automatic write_word(input logic [23:0] w, input int n);
    logic [23:0] sh;
    logic        s;
    sh = w;
    write_frame_strobe_n = 1'b0;  // frame opens before any data
    host_drv = 1'b1;
    #24;
    for (int i = 0; i < n; i++) begin
      slot(1'b1, sh[23], s);
      sh = {sh[22:0], ~sh[0]};
    end
    #40;
    write_frame_strobe_n = 1'b1;
    host_drv = 1'b0;
    #24;
  endtask : write_word

  // Read 24 bits, MSB first
  task automatic read_word(output logic [23:0] w);
    logic s;
    w = 24'h000000;
    read_frame_strobe_n = 1'b0;  // active-low read frame
    #24;
    for (int i = 0; i < 24; i++) begin
      slot(1'b0, 1'b0, s);
      w = {w[22:0], s};
    end
    #40;
    read_frame_strobe_n = 1'b1;
    #24;
  endtask : read_word
endmodule : asp_host_model

//--- verif/asp_serial_port_tb.sv
// Self-checking testbench of the serial host port
`timescale 1ns/1ps

module asp_serial_port_tb;
  logic        core_clk, nrst, host_clk, host_drv, host_bit, link_wire;
  logic        write_frame_strobe_n, read_frame_strobe_n, io_wire;
  logic        register_select, cal_access, cal_sel, mode_sel;
  logic        serial_io_out, serial_io_oe_n, sclk_out, sclk_oe_n;
  logic        result_ready_n, result_valid, cal_done, drove;
  logic [23:0] raw_result, cal_offset_in, cal_gain_in;
  logic [23:0] ctrl_word, offset_cal, gain_cal;
  logic [23:0] m_reg [4];
  logic        m_ready;
  int          err_total, n_checks;

  // Wire levels seen by all parties
  assign link_wire = mode_sel ? (sclk_oe_n ? 1'b1 : sclk_out) : host_clk;
  assign io_wire = !serial_io_oe_n ? serial_io_out
                 : (host_drv ? host_bit : ~host_bit);

  asp_serial_port asp_serial_port_inst (
    .core_clk(core_clk), .nrst(nrst), .link_clk(link_wire),
    .write_frame_strobe_n(write_frame_strobe_n),
    .read_frame_strobe_n(read_frame_strobe_n),
    .register_select(register_select), .cal_access(cal_access),
    .cal_sel(cal_sel), .mode_sel(mode_sel), .serial_io_in(io_wire),
    .serial_io_out(serial_io_out), .serial_io_oe_n(serial_io_oe_n),
    .sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n),
    .result_ready_n(result_ready_n), .result_valid(result_valid),
    .raw_result(raw_result), .cal_done(cal_done),
    .cal_offset_in(cal_offset_in), .cal_gain_in(cal_gain_in),
    .ctrl_word(ctrl_word), .offset_cal(offset_cal), .gain_cal(gain_cal));

  asp_host_model asp_host_model_inst (
    .mode_sel(mode_sel), .link_wire(link_wire), .io_wire(io_wire),
    .host_clk(host_clk), .host_drv(host_drv), .host_bit(host_bit),
    .write_frame_strobe_n(write_frame_strobe_n),
    .read_frame_strobe_n(read_frame_strobe_n));

  // ----------------------------------------------------------------------
  // Clock and drive watcher
  // ----------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (!serial_io_oe_n) drove <= 1'b1;
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input string what, input logic [23:0] seen,
                       input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc

  // Select source, held from 3 cycles before the frame
  task automatic sel(input int src);
    cyc(1);
    register_select = (src != 0);
    cal_access = (src == 1 || src == 2);
    cal_sel = (src == 2);
    cyc(3);
  endtask : sel

  task automatic wr(input int src, input logic [23:0] w, input int n);
    sel(src);
    asp_host_model_inst.write_word(w, n);
    cyc(8);
  endtask : wr

  task automatic rd(input int src, output logic [23:0] w);
    sel(src);
    asp_host_model_inst.read_word(w);
    cyc(8);
  endtask : rd

  task automatic regs_cmp;
    check("ctrl", ctrl_word, m_reg[0]);
    check("offs", offset_cal, m_reg[1]);
    check("gain", gain_cal, m_reg[2]);
    check("ready", {23'h0, result_ready_n}, {23'h0, m_ready});
  endtask : regs_cmp

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up

  // Watchdog against a hung handshake
  initial begin
    #150000;
    err_total++;
    wrap_up();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin : main_seq
    logic [23:0] w, r, raw;
    void'($urandom(32'h00141FE8));
    {nrst, result_valid, cal_done, register_select} = 4'h0;
    {cal_access, cal_sel, mode_sel, drove} = 4'h0;
    {raw_result, cal_offset_in, cal_gain_in} = '0;
    err_total = 0;
    n_checks = 0;
    m_reg = '{default: 24'h000000};
    m_ready = 1'b1;
    cyc(2);
    nrst = 1'b1;
    cyc(6);
    regs_cmp();
    for (int m = 0; m < 2; m++) begin
      mode_sel = m[0];
      for (int s = 0; s < 3; s++) begin
        w = 24'($urandom());
        if (s == 0) w[asp_pkg::CTRL_BU_POS] = m[0];
        wr(s, w, 24);
        m_reg[s] = w;
        regs_cmp();
      end
      for (int s = 0; s < 3; s++) begin
        rd(s, r);
        check("read", r, m_reg[s]);
      end
      if (m == 0) begin
        wr(0, 24'($urandom()), 23);
        regs_cmp();
        w = 24'($urandom());
        w[asp_pkg::CTRL_BU_POS] = 1'b0;
        wr(0, w, 30);
        m_reg[0] = w;
        regs_cmp();
        drove = 1'b0;
        rd(3, r);
        check("refused drive", {23'h0, drove}, 24'h000000);
      end
      cyc(1);
      cal_offset_in = 24'($urandom());
      cal_gain_in = 24'($urandom());
      cal_done = 1'b1;
      cyc(1);
      cal_done = 1'b0;
      cyc(3);
      m_reg[1] = cal_offset_in;
      m_reg[2] = cal_gain_in;
      m_ready = 1'b0;
      regs_cmp();
      raw = 24'($urandom());
      if (m_reg[0][asp_pkg::CTRL_BU_POS]) raw[23] = 1'b0;
      raw_result = raw;
      result_valid = 1'b1;
      cyc(1);
      result_valid = 1'b0;
      cyc(3);
      regs_cmp();
      rd(3, r);
      m_ready = 1'b1;
      w = m_reg[0][asp_pkg::CTRL_BU_POS] ? raw : raw ^ 24'h800000;
      check("data", r, w);
      regs_cmp();
    end
    wrap_up();
  end
endmodule : asp_serial_port_tb
